// *** adc_link_map.svh ***
// constants for the converter serializer link: register map, fields, patterns, timing
// assumes inclusion by bare name from every file that needs it
`ifndef ADC_LINK_MAP_SVH
`define ADC_LINK_MAP_SVH
`define LANES       8
`define MOD_W       3
`define OFS_PAT0    8'h08
`define OFS_PAT1    8'h09
`define OFS_DCTL    8'h0b
`define OFS_OCTL    8'h0c
`define DCTL_EQ     0
`define DCTL_TRAINING_PATTERN_SELECT   2:1
`define OCTL_SLVS   0
`define OCTL_CML    1
`define OCTL_DRV    3:2
`define OCTL_TERM   4
`define DCTL_RST    8'h01
`define OCTL_RST    8'h00
`define PAT_FIXED   8'hf0
`define PAT_TOG_A   8'haa
`define PAT_TOG_B   8'h55
`define WORD_LAST   4'hf
`define CFG_LAST    5'h0f
`define CFG_BITS    5'h10
`define RX_LAST     4'h8
`define RX_SAT      4'hf
`define CLK_NS      20
`define CFG_HALF_NS 1280
`define CFG_HALF_CYC (`CFG_HALF_NS / `CLK_NS)
`define H_CMD       4'h0
`define H_STAT      4'h4
`define H_RX        4'h8
`define RESP_OK     2'b00
`define RESP_ERR    2'b10
`endif

// *** adc_pkg.sv ***
// types shared by both ends of the converter serializer link
// assumes nothing beyond a SystemVerilog compiler
package adc_pkg;
  typedef enum logic [1:0] {
    TS_NORMAL = 2'b00,
    TS_FIXED  = 2'b01,
    TS_TOGGLE = 2'b10,
    TS_CUSTOM = 2'b11
  } training_pattern_select_t;
  typedef enum logic [2:0] {
    CS_IDLE  = 3'b001,
    CS_SHIFT = 3'b010,
    CS_GAP   = 3'b100
  } cfg_state_t;
endpackage

// *** adc_link_if.sv ***
// carrier between the converter end and the receiving controller end
// assumes both ends run the link side on the same link clock
`include "adc_link_map.svh"
interface adc_link_if;
  logic               cfg_clk;
  logic               cfg_sel_n;
  logic               cfg_din;
  logic               bit_clk;
  logic               word_clk;
  logic [`LANES-1:0]  lane;
  modport dev (input cfg_clk, input cfg_sel_n, input cfg_din,
               output bit_clk, output word_clk, output lane);
  modport host (output cfg_clk, output cfg_sel_n, output cfg_din,
                input bit_clk, input word_clk, input lane);
endinterface

// *** adc_serializer_dev.sv ***
// converter end: decimation, equalizer, serial config registers, training, serializer
// assumes link_clk is the converter clock and modulator codes arrive on it
//
// Contract
// - decimate modulator data, rate follows converter clock
// - enabled equalizer keeps group delay flat
// - equalizer bypassed by decimator control write
// - word and bit clocks locked to converter clock
// - output control bit0 selects low-voltage mode
// - common level bit clear gives reduced level
// - common level bit set gives standard level
// - drive current default lowest, two higher
// - termination bit one enables internal termination
// - training pattern on all eight lanes
// - clocks keep running during training
// - training chosen by decimator control field
// - two fixed patterns, one custom pair
// - training select resets to normal output
`include "adc_link_map.svh"
module adc_serializer_dev
  import adc_pkg::*;
(
  input  wire logic                       link_clk,
  input  wire logic                       reset_n,
  input  wire logic [`LANES*`MOD_W-1:0]   mod_data,
  adc_link_if.dev                         lnk,
  output logic                            slvs_en,
  output logic                            common_level_select,
  output logic [1:0]                      drive_sel,
  output logic                            term_en,
  output logic                            eq_active
);

  typedef struct packed {
    // reset and config port synchronisers, frame shifter
    logic [1:0]                  rst_s;
    logic [2:0]                  cs_clk;
    logic [1:0]                  cs_sel;
    logic [1:0]                  cs_din;
    logic [15:0]                 cfg_sr;
    logic [4:0]                  cfg_cnt;
    // registers as written, then their word-boundary shadows
    logic [7:0]                  pat0;
    logic [7:0]                  pat1;
    logic [7:0]                  dctl;
    logic [7:0]                  octl;
    logic [7:0]                  pat0_sh;
    logic [7:0]                  pat1_sh;
    logic [7:0]                  dctl_sh;
    logic [7:0]                  octl_sh;
    // word timing, decimator and equalizer history
    logic [3:0]                  cyc;
    logic                        alt;
    logic [`LANES-1:0][6:0]      acc;
    logic [`LANES-1:0][7:0]      x1;
    logic [`LANES-1:0][7:0]      x2;
    logic [`LANES-1:0][7:0]      word;
    // link pins
    logic                        bit_clk;
    logic                        word_clk;
    logic [`LANES-1:0]           lane;
  } dev_state_t;

  dev_state_t s_r;
  dev_state_t s_nxt;

  // one register write from the serial port
  function automatic dev_state_t reg_write(input dev_state_t st,
                                           input logic [7:0] adr,
                                           input logic [7:0] dat);
    dev_state_t r;
    r = st;
    case (adr)
      `OFS_PAT0: r.pat0 = dat;
      `OFS_PAT1: r.pat1 = dat;
      `OFS_DCTL: r.dctl = dat;
      `OFS_OCTL: r.octl = dat;
      default:   r = st;
    endcase
    return r;
  endfunction

  // decimated word, through the three-tap equalizer when it is on
  function automatic logic [7:0] filt_word(input logic [7:0] x,
                                           input logic [7:0] x1,
                                           input logic [7:0] x2,
                                           input logic       eq_on);
    logic [9:0] f;
    // symmetric taps give constant delay across the band
    f = 10'(x) + {1'b0, x1, 1'b0} + 10'(x2);
    if (eq_on) begin
      filt_word = f[9:2];
    end else begin
      filt_word = x;
    end
  endfunction

  // word source of a lane: sample data or one of the training patterns
  function automatic logic [7:0] lane_word(input training_pattern_select_t      sel,
                                           input logic       odd,
                                           input logic [7:0] p0,
                                           input logic [7:0] p1,
                                           input logic [7:0] y);
    case (sel)
      TS_NORMAL: lane_word = y;
      TS_FIXED:  lane_word = `PAT_FIXED;
      TS_TOGGLE: lane_word = odd ? `PAT_TOG_B : `PAT_TOG_A;
      TS_CUSTOM: lane_word = odd ? p1 : p0;
      default:   lane_word = y;
    endcase
  endfunction

  // msb leaves first, each bit held for two converter clocks
  function automatic logic lane_bit(input logic [7:0] w,
                                    input logic [3:0] c);
    lane_bit = w[~c[3:1]];
  endfunction

  always_comb begin
    logic [6:0] sum;
    logic [7:0] x;
    logic [7:0] y;
    logic       wrap;
    sum   = '0;
    x     = '0;
    y     = '0;
    wrap  = 1'b0;
    s_nxt = s_r;

    // reset and serial config pins, sampled through two flops before use
    s_nxt.rst_s  = {s_r.rst_s[0], reset_n};
    s_nxt.cs_clk = {s_r.cs_clk[1:0], lnk.cfg_clk};
    s_nxt.cs_sel = {s_r.cs_sel[0], lnk.cfg_sel_n};
    s_nxt.cs_din = {s_r.cs_din[0], lnk.cfg_din};
    // select high drops a short frame; bits past the sixteenth are ignored
    if (s_r.cs_sel[1]) begin
      s_nxt.cfg_cnt = '0;
    end else if (s_r.cs_clk[1] && !s_r.cs_clk[2] && s_r.cfg_cnt != `CFG_BITS) begin
      s_nxt.cfg_sr  = {s_r.cfg_sr[14:0], s_r.cs_din[1]};
      s_nxt.cfg_cnt = s_r.cfg_cnt + 5'h01;
      if (s_r.cfg_cnt == `CFG_LAST) begin
        s_nxt = reg_write(s_nxt, s_nxt.cfg_sr[15:8], s_nxt.cfg_sr[7:0]);
      end
    end

    // word timing counted straight off the converter clock
    s_nxt.cyc = s_r.cyc + 4'h1;
    wrap      = (s_r.cyc == `WORD_LAST);

    // settings move to the serializer only between words
    if (wrap) begin
      s_nxt.pat0_sh = s_nxt.pat0;
      s_nxt.pat1_sh = s_nxt.pat1;
      s_nxt.dctl_sh = s_nxt.dctl;
      s_nxt.octl_sh = s_nxt.octl;
      s_nxt.alt     = !s_r.alt;
    end

    // every lane runs the same decimator and serializer
    for (int i = 0; i < `LANES; i++) begin
      // integrate and dump over one word time, one output per sixteen inputs
      sum = s_r.acc[i] + 7'(mod_data[i*`MOD_W +: `MOD_W]);
      s_nxt.acc[i] = wrap ? 7'h00 : sum;
      if (wrap) begin
        x = {sum, 1'b0};
        y = filt_word(x, s_r.x1[i], s_r.x2[i], s_nxt.dctl_sh[`DCTL_EQ]);
        if (s_nxt.dctl_sh[`DCTL_EQ]) begin
          s_nxt.x1[i] = x;
          s_nxt.x2[i] = s_r.x1[i];
        end
        s_nxt.word[i] = lane_word(training_pattern_select_t'(s_nxt.dctl_sh[`DCTL_TRAINING_PATTERN_SELECT]), s_r.alt,
                                  s_nxt.pat0_sh, s_nxt.pat1_sh, y);
      end
      s_nxt.lane[i] = lane_bit(s_nxt.word[i], s_nxt.cyc);
    end

    // clocks are free running whatever the data source is
    s_nxt.bit_clk  = s_nxt.cyc[0];
    s_nxt.word_clk = !s_nxt.cyc[3];

    // everything holds its reset value until the resynchronised reset lets go
    if (!s_r.rst_s[1]) begin
      s_nxt         = '0;
      s_nxt.rst_s   = {s_r.rst_s[0], reset_n};
      s_nxt.dctl    = `DCTL_RST;
      s_nxt.dctl_sh = `DCTL_RST;
      s_nxt.octl    = `OCTL_RST;
      s_nxt.octl_sh = `OCTL_RST;
      s_nxt.word_clk = 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    s_r <= s_nxt;
  end

  // link pins straight from the state flops
  assign lnk.bit_clk          = s_r.bit_clk;
  assign lnk.word_clk         = s_r.word_clk;
  assign lnk.lane             = s_r.lane;
  // slvs and the common level bit drive their outputs independently
  assign slvs_en              = s_r.octl_sh[`OCTL_SLVS];
  assign common_level_select  = s_r.octl_sh[`OCTL_CML];
  assign drive_sel            = s_r.octl_sh[`OCTL_DRV];
  assign term_en              = s_r.octl_sh[`OCTL_TERM];
  assign eq_active            = s_r.dctl_sh[`DCTL_EQ];

endmodule

// *** adc_receiver_host.sv ***
// controller end: axi4-lite registers, serial config writer, lane deserializer
// assumes link_clk is the same clock that runs the converter end
//
// Our own choice: the AXI4-Lite register port.
`include "adc_link_map.svh"
module adc_receiver_host
  import adc_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic         link_clk,
  adc_link_if.host          lnk,
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready
);

  typedef struct packed {
    logic [1:0]              rst_s;
    logic                    bc_p;
    logic                    wc_p;
    logic [3:0]              cnt;
    logic [`LANES-1:0][7:0]  sr;
    logic [7:0]              hold_w;
    logic                    hold_eq;
    logic                    tog;
  } link_state_t;

  typedef struct packed {
    logic [2:0]  tsync;
    logic [7:0]  rx_w;
    logic        rx_eq;
    logic        seen;
    cfg_state_t  st;
    logic [5:0]  div;
    logic [4:0]  bits;
    logic [15:0] sr;
    logic [15:0] last_cmd;
    logic        cclk;
    logic        csel_n;
    logic        cdin;
    logic        aw_h;
    logic [3:0]  aw_a;
    logic        w_h;
    logic [15:0] w_d;
    logic        w_full;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } host_state_t;

  link_state_t l_r;
  link_state_t l_nxt;
  host_state_t h_r;
  host_state_t h_nxt;

  // link side: rebuild one word per lane from bit and word clocks
  always_comb begin
    logic all_eq;
    all_eq = 1'b1;
    l_nxt  = l_r;
    l_nxt.rst_s = {l_r.rst_s[0], reset_n};
    if (lnk.bit_clk && !l_r.bc_p) begin
      for (int i = 0; i < `LANES; i++) begin
        l_nxt.sr[i] = {l_r.sr[i][6:0], lnk.lane[i]};
      end
      l_nxt.wc_p = lnk.word_clk;
      if (lnk.word_clk && !l_r.wc_p) begin
        l_nxt.cnt = 4'h1;
      end else if (l_r.cnt != `RX_SAT) begin
        l_nxt.cnt = l_r.cnt + 4'h1;
      end
      if (l_nxt.cnt == `RX_LAST) begin
        for (int i = 1; i < `LANES; i++) begin
          all_eq = all_eq && (l_nxt.sr[i] == l_nxt.sr[0]);
        end
        // training words should match on every lane
        l_nxt.hold_w  = l_nxt.sr[0];
        l_nxt.hold_eq = all_eq;
        l_nxt.tog     = !l_r.tog;
      end
    end
    l_nxt.bc_p = lnk.bit_clk;
    if (!l_r.rst_s[1]) begin
      l_nxt       = '0;
      l_nxt.rst_s = {l_r.rst_s[0], reset_n};
    end
  end

  always_ff @(posedge link_clk) begin
    l_r <= l_nxt;
  end

  // system side: register bus, word capture, config frame writer
  always_comb begin
    logic do_wr;
    do_wr = h_r.aw_h && h_r.w_h && !h_r.bvalid;
    h_nxt = h_r;
    h_nxt.tsync = {h_r.tsync[1:0], l_r.tog};

    if (h_r.bvalid && s_axi_bready) begin
      h_nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid && h_r.awready) begin
      h_nxt.aw_h = 1'b1;
      h_nxt.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && h_r.wready) begin
      h_nxt.w_h    = 1'b1;
      h_nxt.w_d    = s_axi_wdata[15:0];
      h_nxt.w_full = &s_axi_wstrb[1:0];
    end
    if (do_wr) begin
      h_nxt.aw_h   = 1'b0;
      h_nxt.w_h    = 1'b0;
      h_nxt.bvalid = 1'b1;
      h_nxt.bresp  = `RESP_OK;
      case (h_r.aw_a)
        `H_CMD: begin
          if (h_r.st == CS_IDLE && h_r.w_full) begin
            // address byte then data byte, msb first
            h_nxt.last_cmd = h_r.w_d;
            h_nxt.sr       = h_r.w_d;
            h_nxt.cdin     = h_r.w_d[15];
            h_nxt.csel_n   = 1'b0;
            h_nxt.cclk     = 1'b0;
            h_nxt.div      = '0;
            h_nxt.bits     = '0;
            h_nxt.st       = CS_SHIFT;
          end else begin
            h_nxt.bresp = `RESP_ERR;
          end
        end
        `H_STAT, `H_RX: h_nxt.bresp = `RESP_OK;
        default:        h_nxt.bresp = `RESP_ERR;
      endcase
    end

    if (h_r.rvalid && s_axi_rready) begin
      h_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && h_r.arready) begin
      h_nxt.rvalid = 1'b1;
      h_nxt.rresp  = `RESP_OK;
      case (s_axi_araddr)
        `H_CMD:  h_nxt.rdata = {16'h0000, h_r.last_cmd};
        `H_STAT: h_nxt.rdata = {30'h0, h_r.seen, h_r.st != CS_IDLE};
        `H_RX: begin
          h_nxt.rdata = {23'h0, h_r.rx_eq, h_r.rx_w};
          h_nxt.seen  = 1'b0;
        end
        default: begin
          h_nxt.rdata = '0;
          h_nxt.rresp = `RESP_ERR;
        end
      endcase
    end

    // a fresh word wins over the read clear
    if (h_r.tsync[2] != h_r.tsync[1]) begin
      h_nxt.rx_w  = l_r.hold_w;
      h_nxt.rx_eq = l_r.hold_eq;
      h_nxt.seen  = 1'b1;
    end

    case (h_r.st)
      CS_IDLE: h_nxt.div = '0;
      CS_SHIFT: begin
        h_nxt.div = h_r.div + 6'h01;
        if (h_r.div == 6'(`CFG_HALF_CYC - 1)) begin
          h_nxt.div  = '0;
          h_nxt.cclk = !h_r.cclk;
          if (h_r.cclk) begin
            if (h_r.bits == `CFG_LAST) begin
              h_nxt.st = CS_GAP;
            end else begin
              h_nxt.bits = h_r.bits + 5'h01;
              h_nxt.sr   = {h_r.sr[14:0], 1'b0};
              h_nxt.cdin = h_r.sr[14];
            end
          end
        end
      end
      CS_GAP: begin
        h_nxt.div = h_r.div + 6'h01;
        if (h_r.div == 6'(`CFG_HALF_CYC - 1)) begin
          h_nxt.div    = '0;
          h_nxt.csel_n = 1'b1;
          h_nxt.st     = CS_IDLE;
        end
      end
      default: h_nxt.st = CS_IDLE;
    endcase

    if (!reset_n) begin
      h_nxt        = '0;
      h_nxt.st     = CS_IDLE;
      h_nxt.csel_n = 1'b1;
    end
    h_nxt.awready = !h_nxt.aw_h;
    h_nxt.wready  = !h_nxt.w_h;
    h_nxt.arready = !h_nxt.rvalid;
  end

  always_ff @(posedge clock) begin
    h_r <= h_nxt;
  end

  assign lnk.cfg_clk    = h_r.cclk;
  assign lnk.cfg_sel_n  = h_r.csel_n;
  assign lnk.cfg_din    = h_r.cdin;
  assign s_axi_awready  = h_r.awready;
  assign s_axi_wready   = h_r.wready;
  assign s_axi_bvalid   = h_r.bvalid;
  assign s_axi_bresp    = h_r.bresp;
  assign s_axi_arready  = h_r.arready;
  assign s_axi_rvalid   = h_r.rvalid;
  assign s_axi_rresp    = h_r.rresp;
  assign s_axi_rdata    = h_r.rdata;

endmodule

// *** adc_link_sva.sv ***
// checker for the serializer link carrier: framing of config and data clocks
// assumes the bench feeds the carrier signals and one shared active-low reset
`include "adc_link_map.svh"
module adc_link_sva (
  input wire logic        link_clk,
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        cfg_clk,
  input wire logic        cfg_sel_n,
  input wire logic        cfg_din,
  input wire logic        bit_clk,
  input wire logic        word_clk,
  input wire logic [7:0]  lane
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_d;
  logic [2:0]  lrst_r;
  logic        sel_d;
  logic [15:0] cnt_r;
  logic [4:0]  rise_r;
  logic        ev;
  assign ev = (cfg_clk != clk_d) || (cfg_sel_n != sel_d);
  // spacing of config edges and count of rising edges within a frame
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      clk_d  <= 1'b0;
      sel_d  <= 1'b1;
      cnt_r  <= 16'h0000;
      rise_r <= 5'h00;
    end else begin
      clk_d  <= cfg_clk;
      sel_d  <= cfg_sel_n;
      cnt_r  <= ev ? 16'h0000 : cnt_r + 16'h0001;
      rise_r <= cfg_sel_n ? 5'h00 : rise_r + {4'h0, cfg_clk & ~clk_d};
    end
  end
  // the converter end leaves reset three link clocks after the pin is released
  always_ff @(posedge link_clk) begin
    lrst_r <= {lrst_r[1:0], reset_n};
  end
  AST_BIT_TOGGLE: assert property (@(posedge link_clk) disable iff (!reset_n)
    lrst_r[2] |-> bit_clk != $past(bit_clk)) else $error("bit clock missed a toggle");
  AST_WORD_SHAPE: assert property (@(posedge link_clk) disable iff (!reset_n)
    $rose(word_clk) |-> word_clk [*8] ##1 !word_clk [*8]) else $error("word clock shape");
  AST_WORD_ALIGN: assert property (@(posedge link_clk) disable iff (!reset_n)
    $rose(word_clk) |-> !bit_clk) else $error("word clock not aligned to bit clock");
  AST_LANE_EDGE: assert property (@(posedge link_clk) disable iff (!reset_n)
    $changed(lane) |-> !bit_clk) else $error("lane changed while bit clock high");
  AST_CFG_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
    cfg_sel_n |-> !cfg_clk) else $error("config clock active outside frame");
  AST_CFG_DIN: assert property (@(posedge clock) disable iff (!reset_n)
    !cfg_sel_n && $changed(cfg_din) |-> !cfg_clk) else $error("config data moved while clock high");
  AST_CFG_HALF: assert property (@(posedge clock) disable iff (!reset_n)
    ev && !sel_d |-> cnt_r == `CFG_HALF_CYC - 1) else $error("config half period wrong");
  AST_FRAME_BITS: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(cfg_sel_n) |-> rise_r == `CFG_BITS) else $error("config frame bit count wrong");
  COV_FRAME: cover property (@(posedge clock) disable iff (!reset_n) $rose(cfg_sel_n));
  COV_WORD: cover property (@(posedge link_clk) disable iff (!reset_n) $rose(word_clk));
  COV_FIXED: cover property (@(posedge link_clk) disable iff (!reset_n) lane == 8'hff);
endmodule

// *** tb_adc_output_serializer_control.sv ***
// self-checking bench: host end and converter end joined by the link carrier
// assumes the design files and adc_link_map.svh are compiled first
`include "adc_link_map.svh"
module tb_adc_output_serializer_control
  import adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, reset_n, link_clk;
  logic [23:0] mod_data;
  logic        slvs_en, common_level_select, term_en, eq_active;
  logic [1:0]  drive_sel, s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d1, d2;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          error_cnt, checked;
  logic [7:0]  octl [7] = '{8'h01, 8'h03, 8'h02, 8'h06, 8'h0a, 8'h10, 8'h00};
  logic [7:0]  pa [3] = '{`PAT_FIXED, `PAT_TOG_A, 8'h3c};
  logic [7:0]  pb [3] = '{`PAT_FIXED, `PAT_TOG_B, 8'hc3};
  adc_link_if link ();
  adc_serializer_dev adc_serializer_dev_inst (.link_clk, .reset_n, .mod_data, .lnk(link),
    .slvs_en, .common_level_select, .drive_sel, .term_en, .eq_active);
  adc_receiver_host adc_receiver_host_inst (.clock, .reset_n, .link_clk, .lnk(link),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  adc_link_sva adc_link_sva_inst (.link_clk, .clock, .reset_n, .cfg_clk(link.cfg_clk),
    .cfg_sel_n(link.cfg_sel_n), .cfg_din(link.cfg_din), .bit_clk(link.bit_clk),
    .word_clk(link.word_clk), .lane(link.lane));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end
  task automatic final_report();
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    int n;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 64) begin
      error_cnt++;
      final_report();
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 64) begin
      error_cnt++;
      final_report();
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic wait_idle();
    int n;
    logic [31:0] st;
    for (n = 0; n < 3000; n++) begin
      axi_rd(`H_STAT, st, `RESP_OK);
      if (st[0] === 1'b0) break;
    end
    if (n == 3000) begin
      error_cnt++;
      final_report();
    end
    repeat (24) @(posedge link_clk);
  endtask
  // one config frame, then wait until the register has reached the link side
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    axi_wr(`H_CMD, {16'h0000, a, d}, 4'hf, `RESP_OK);
    wait_idle();
  endtask
  task automatic chk_out(input logic [7:0] o, input logic e);
    chk({26'h0, slvs_en, common_level_select, drive_sel, term_en, eq_active},
        {26'h0, o[0], o[1], o[3:2], o[4], e});
  endtask
  initial begin
    reset_n = 1'b0;
    mod_data = {{7{3'h3}}, 3'h2};
    {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    error_cnt = 0;
    checked = 0;
    repeat (4) @(posedge link_clk);
    @(posedge clock);
    reset_n <= 1'b1;
    repeat (80) @(posedge link_clk);
    chk_out(8'h00, 1'b1);
    axi_rd(`H_STAT, d1, `RESP_OK);
    chk(d1, 32'h0000_0002);
    axi_rd(`H_RX, d1, `RESP_OK);
    chk({23'h0, d1[8:0]}, 32'h0000_0040);
    axi_rd(4'hc, d1, `RESP_ERR);
    chk(d1, 32'h0);
    axi_wr(`H_STAT, 32'h0, 4'hf, `RESP_OK);
    axi_wr(`H_CMD, {16'h0, `OFS_OCTL, 8'h01}, 4'h1, `RESP_ERR);
    axi_wr(`H_CMD, {16'h0, `OFS_PAT0, 8'h3c}, 4'hf, `RESP_OK);
    axi_wr(`H_CMD, {16'h0, `OFS_PAT1, 8'hc3}, 4'hf, `RESP_ERR);
    wait_idle();
    dev_wr(`OFS_PAT1, 8'hc3);
    axi_rd(`H_CMD, d1, `RESP_OK);
    chk({16'h0, d1[15:0]}, {16'h0, `OFS_PAT1, 8'hc3});
    for (int i = 0; i < 7; i++) begin
      dev_wr(`OFS_OCTL, octl[i]);
      chk_out(octl[i], 1'b1);
    end
    for (int t = 1; t < 4; t++) begin
      dev_wr(`OFS_DCTL, {5'h00, training_pattern_select_t'(t), 1'b1});
      repeat (48) @(posedge link_clk);
      axi_rd(`H_RX, d1, `RESP_OK);
      repeat (16) @(posedge link_clk);
      axi_rd(`H_RX, d2, `RESP_OK);
      chk({22'h0, d1[8], d1[7:0] == pa[t-1] || d1[7:0] == pb[t-1], d1[7:0] ^ d2[7:0]},
          {22'h0, 2'b11, pa[t-1] ^ pb[t-1]});
    end
    dev_wr(`OFS_DCTL, 8'h00);
    chk_out(8'h00, 1'b0);
    repeat (64) @(posedge link_clk);
    axi_rd(`H_RX, d1, `RESP_OK);
    chk({23'h0, d1[8:0]}, 32'h0000_0040);
    final_report();
  end
endmodule
